// *** logic/latched_sram_host.sv ***
// Contract
// - Pure write: write enable low before enable falls, until it rises.
// - Late write enable: wait output disable time before driving data.
// - Hold enable high for the minimum high time between cycles.
// - Back-to-back writes may keep write enable low, toggling enable.
// - Combined cycle: read data first, then pulse write enable minimum width.
// - Address valid only around enable fall; fresh fall every cycle.
// - In backup keep enable high and other pins steady at a rail (here ramAddr stays at the last request address).
// - After backup wait one enable-high time after supply good.
// - Pure read keeps write enable high while enable is low.
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_consts.svh"
module latched_sram_host (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   // User request side
   input  wire logic                 reqValid,
   output logic                      reqReady,
   input  wire logic [1:0]           reqOp,
   input  wire logic [`ADDR_W-1:0]   reqAddr,
   input  wire logic [`DATA_W-1:0]   reqWdata,
   input  wire logic                 reqBurst,
   output logic                      rspValid,
   output logic      [`DATA_W-1:0]   rspRdata,
   input  wire logic                 backupReq,
   input  wire logic                 supplyGood,
   output logic                      inBackup,
   // RAM pins
   output logic                      ramEnableN,
   output logic                      ramWriteN,
   output logic      [`ADDR_W-1:0]   ramAddr,
   output logic      [`DATA_W-1:0]   ramDataOut,
   output logic                      ramDataOe,
   input  wire logic [`DATA_W-1:0]   ramDataIn
);
   sram_ctrl_pkg::state_t state_q, state_d;
   sram_ctrl_pkg::op_t    op_q, op_d;
   logic [`CNT_W-1:0]     cnt_q, cnt_d;
   logic                  en_q, en_d, we_q, we_d, oe_q, oe_d;
   logic                  burst_q, burst_d, rsp_q, rsp_d;
   logic [`ADDR_W-1:0]    addr_q, addr_d;
   logic [`DATA_W-1:0]    wd_q, wd_d, rd_q, rd_d;
   logic [3:0]            syncOut;
   logic [`DATA_W-1:0]    dataSync;

   // Read data and nothing else crosses in from the pins
   pin_sync u_sync (
      .mclk   (mclk),
      .rst    (rst),
      .pinIn  (ramDataIn),
      .pinOut (syncOut)
   );
   assign dataSync = syncOut;

   function automatic logic [`CNT_W-1:0] cyc(input int n);
      cyc = `CNT_W'(n);
   endfunction : cyc

   // Synchroniser latency added so sampled data is really settled
   localparam int SAMPLE_CYC = `ENABLE_ACCESS_CYC + 3;

   always_comb begin
      state_d = state_q;
      op_d    = op_q;
      cnt_d   = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
      en_d    = en_q;
      we_d    = we_q;
      oe_d    = oe_q;
      burst_d = burst_q;
      addr_d  = addr_q;
      wd_d    = wd_q;
      rd_d    = rd_q;
      rsp_d   = 1'b0;
      case (state_q)
         sram_ctrl_pkg::ST_IDLE: begin
            if (backupReq) begin
               state_d = sram_ctrl_pkg::ST_BACKUP;
               we_d    = 1'b0;
               oe_d    = 1'b0;
            end else if (reqValid) begin
               op_d    = sram_ctrl_pkg::op_t'(reqOp);
               addr_d  = reqAddr;
               wd_d    = reqWdata;
               burst_d = reqBurst;
               // Pure write: write enable low before enable falls
               we_d    = (reqOp == 2'h1);
               oe_d    = 1'b0;
               cnt_d   = cyc(`ADDR_SETUP_CYC);
               state_d = sram_ctrl_pkg::ST_SETUP;
            end else if (!burst_q) begin
               we_d = 1'b0;
            end
         end
         sram_ctrl_pkg::ST_SETUP: begin
            if (cnt_q == '0) begin
               en_d    = 1'b1;
               cnt_d   = cyc(`ADDR_HOLD_CYC);
               state_d = sram_ctrl_pkg::ST_HOLD;
            end
         end
         sram_ctrl_pkg::ST_HOLD: begin
            if (cnt_q == '0) begin
               // Address need not stay valid past the hold window
               if (op_q == sram_ctrl_pkg::OP_WRITE) begin
                  oe_d    = 1'b1;
                  cnt_d   = cyc(`ENABLE_LOW_CYC - `ADDR_HOLD_CYC);
                  state_d = sram_ctrl_pkg::ST_LOWTAIL;
               end else begin
                  cnt_d   = cyc(SAMPLE_CYC - `ADDR_HOLD_CYC);
                  state_d = sram_ctrl_pkg::ST_ACCESS;
               end
            end
         end
         sram_ctrl_pkg::ST_ACCESS: begin
            if (cnt_q == '0) begin
               rd_d = dataSync;
               if (op_q == sram_ctrl_pkg::OP_RMW) begin
                  rsp_d   = 1'b1;
                  we_d    = 1'b1;
                  cnt_d   = cyc(`WRITE_OUT_DIS_CYC);
                  state_d = sram_ctrl_pkg::ST_WRPULSE;
               end else begin
                  rsp_d   = 1'b1;
                  en_d    = 1'b0;
                  cnt_d   = cyc(`ENABLE_HIGH_CYC);
                  state_d = sram_ctrl_pkg::ST_HIGH;
               end
            end
         end
         sram_ctrl_pkg::ST_WRPULSE: begin
            // Late write enable: RAM may still drive, so wait before data
            if (cnt_q == '0 && !oe_q) begin
               oe_d  = 1'b1;
               cnt_d = cyc(`WRITE_PULSE_CYC - `WRITE_OUT_DIS_CYC);
            end else if (cnt_q == '0) begin
               we_d    = 1'b0;
               oe_d    = 1'b0;
               cnt_d   = cyc(1);
               state_d = sram_ctrl_pkg::ST_LOWTAIL;
            end
         end
         sram_ctrl_pkg::ST_LOWTAIL: begin
            if (cnt_q == '0) begin
               en_d = 1'b0;
               if (!burst_q || op_q != sram_ctrl_pkg::OP_WRITE) begin
                  we_d = 1'b0;
               end
               oe_d    = 1'b0;
               if (op_q == sram_ctrl_pkg::OP_WRITE) begin
                  rsp_d = 1'b1;
               end
               cnt_d   = cyc(`ENABLE_HIGH_CYC);
               state_d = sram_ctrl_pkg::ST_HIGH;
            end
         end
         sram_ctrl_pkg::ST_HIGH: begin
            if (cnt_q == '0) begin
               state_d = sram_ctrl_pkg::ST_IDLE;
            end
         end
         sram_ctrl_pkg::ST_BACKUP: begin
            // No refresh is issued; the array is static
            if (backupReq || !supplyGood) begin
               cnt_d = cyc(`ENABLE_HIGH_CYC);
            end else if (cnt_q == '0) begin
               state_d = sram_ctrl_pkg::ST_IDLE;
            end
         end
         default: state_d = sram_ctrl_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= sram_ctrl_pkg::ST_IDLE;
         op_q    <= sram_ctrl_pkg::OP_READ;
         cnt_q   <= '0;
         en_q    <= 1'b0;
         we_q    <= 1'b0;
         oe_q    <= 1'b0;
         burst_q <= 1'b0;
         addr_q  <= '0;
         wd_q    <= '0;
         rd_q    <= '0;
         rsp_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q    <= op_d;
         cnt_q   <= cnt_d;
         en_q    <= en_d;
         we_q    <= we_d;
         oe_q    <= oe_d;
         burst_q <= burst_d;
         addr_q  <= addr_d;
         wd_q    <= wd_d;
         rd_q    <= rd_d;
         rsp_q   <= rsp_d;
      end
   end

   assign reqReady   = (state_q == sram_ctrl_pkg::ST_IDLE) && !backupReq;
   assign rspValid   = rsp_q;
   assign rspRdata   = rd_q;
   assign inBackup   = (state_q == sram_ctrl_pkg::ST_BACKUP);
   assign ramEnableN = !en_q;
   assign ramWriteN  = !we_q;
   assign ramAddr    = addr_q;
   assign ramDataOut = wd_q;
   assign ramDataOe  = oe_q;
endmodule : latched_sram_host
`default_nettype wire

// *** logic/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_consts.svh"
// Three-stage synchroniser; output follows once stages two and three agree
module pin_sync (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [3:0] pinIn,
   output logic      [3:0] pinOut
);
   logic [3:0] s1_q, s2_q, s3_q, out_q;
   logic [3:0] s1_d, s2_d, s3_d, out_d;

   always_comb begin
      s1_d = pinIn;
      s2_d = s1_q;
      s3_d = s2_q;
      out_d = out_q;
      for (int i = 0; i < 4; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_q  <= 4'h0;
         s2_q  <= 4'h0;
         s3_q  <= 4'h0;
         out_q <= 4'h0;
      end else begin
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         s3_q  <= s3_d;
         out_q <= out_d;
      end
   end

   assign pinOut = out_q;
endmodule : pin_sync
`default_nettype wire

// *** logic/sram_ctrl_consts.svh ***
`ifndef SRAM_CTRL_CONSTS_SVH
`define SRAM_CTRL_CONSTS_SVH

`define ADDR_W              9
`define DATA_W              4
`define CLK_PERIOD_NS       10
// Pin timing in ns, then cycle counts (minimums rounded up)
`define ENABLE_HIGH_MIN_NS  150
`define ADDR_SETUP_NS       20
`define ADDR_HOLD_NS        50
`define ENABLE_LOW_MIN_NS   350
`define WRITE_PULSE_MIN_NS  350
`define DATA_SETUP_WE_NS    250
`define WRITE_OUT_DIS_NS    100
`define ENABLE_ACCESS_NS    350
`define OUT_DISABLE_NS      100
`define NS2CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENABLE_HIGH_CYC     `NS2CYC(`ENABLE_HIGH_MIN_NS)
`define ADDR_SETUP_CYC      `NS2CYC(`ADDR_SETUP_NS)
`define ADDR_HOLD_CYC       `NS2CYC(`ADDR_HOLD_NS)
`define ENABLE_LOW_CYC      `NS2CYC(`ENABLE_LOW_MIN_NS)
`define WRITE_PULSE_CYC     `NS2CYC(`WRITE_PULSE_MIN_NS)
`define DATA_SETUP_WE_CYC   `NS2CYC(`DATA_SETUP_WE_NS)
`define WRITE_OUT_DIS_CYC   `NS2CYC(`WRITE_OUT_DIS_NS)
`define ENABLE_ACCESS_CYC   `NS2CYC(`ENABLE_ACCESS_NS)
`define OUT_DISABLE_CYC     `NS2CYC(`OUT_DISABLE_NS)
`define CNT_W               8

`endif

// *** logic/sram_ctrl_pkg.sv ***
`default_nettype none
package sram_ctrl_pkg;
   typedef enum logic [1:0] {
      OP_READ,
      OP_WRITE,
      OP_RMW
   } op_t;

   typedef enum {
      ST_IDLE,
      ST_SETUP,
      ST_HOLD,
      ST_ACCESS,
      ST_WRPULSE,
      ST_LOWTAIL,
      ST_HIGH,
      ST_BACKUP
   } state_t;
endpackage : sram_ctrl_pkg
`default_nettype wire

// *** tb/latched_sram_host_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_consts.svh"
module latched_sram_host_asserts (
   input wire logic               mclk,
   input wire logic               rst,
   input wire logic               ramEnableN,
   input wire logic               ramWriteN,
   input wire logic [`ADDR_W-1:0] ramAddr,
   input wire logic               ramDataOe,
   input wire logic               rspValid,
   input wire logic               inBackup,
   input wire logic               supplyGood
);
   logic [7:0] hiCnt_q, hiCnt_d, wlCnt_q, wlCnt_d, sgCnt_q, sgCnt_d;
   // Saturating run counters; 8 bits is plenty for the 15- and 35-cycle minimums
   function automatic logic [7:0] bump(input logic c, input logic [7:0] v);
      return !c ? 8'h00 : ((v == 8'hff) ? v : v + 8'h01);
   endfunction : bump
   always_comb begin
      hiCnt_d = bump(ramEnableN, hiCnt_q);
      wlCnt_d = bump(!ramWriteN, wlCnt_q);
      sgCnt_d = bump(supplyGood, sgCnt_q);
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hiCnt_q <= 8'hff;
         wlCnt_q <= 8'h00;
         sgCnt_q <= 8'hff;
      end else begin
         hiCnt_q <= hiCnt_d;
         wlCnt_q <= wlCnt_d;
         sgCnt_q <= sgCnt_d;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_oe_in_write;
      ramDataOe |-> !ramWriteN && !ramEnableN;
   endproperty
   a_oe_in_write: assert property (p_oe_in_write)
      else $error("host drives data outside a write");
   property p_enable_high;
      $fell(ramEnableN) |-> hiCnt_q >= 8'h0f;
   endproperty
   a_enable_high: assert property (p_enable_high)
      else $error("enable high time too short");
   property p_write_width;
      $rose(ramWriteN) |-> wlCnt_q >= 8'h23;
   endproperty
   a_write_width: assert property (p_write_width)
      else $error("write pulse too short");
   property p_addr_window;
      $fell(ramEnableN) |-> $past(ramAddr, 2) == ramAddr
         ##0 ($stable(ramAddr))[*5];
   endproperty
   a_addr_window: assert property (p_addr_window)
      else $error("address not held around enable fall");
   property p_late_write;
      // Ten quiet samples cover the full output disable time
      $fell(ramWriteN) && !ramEnableN |->
         (!ramDataOe)[*8] ##1 (!ramDataOe)[*2];
   endproperty
   a_late_write: assert property (p_late_write)
      else $error("data driven too soon after late write enable");
   property p_backup_pins;
      inBackup |-> ramEnableN && !ramDataOe;
   endproperty
   a_backup_pins: assert property (p_backup_pins)
      else $error("enable not high in backup");
   property p_backup_steady;
      inBackup && $past(inBackup) |-> $stable(ramWriteN) && $stable(ramAddr);
   endproperty
   a_backup_steady: assert property (p_backup_steady)
      else $error("pins move during backup");
   property p_supply_wait;
      $fell(ramEnableN) |-> sgCnt_q >= 8'h0f;
   endproperty
   a_supply_wait: assert property (p_supply_wait)
      else $error("cycle started too soon after supply good");
   c_rmw: cover property ($fell(ramWriteN) && !ramEnableN);
   c_rsp: cover property (rspValid);
   c_backup: cover property ($fell(inBackup));
endmodule : latched_sram_host_asserts
bind latched_sram_host latched_sram_host_asserts chk_i (.mclk(mclk),
   .rst(rst), .ramEnableN(ramEnableN), .ramWriteN(ramWriteN),
   .ramAddr(ramAddr), .ramDataOe(ramDataOe), .rspValid(rspValid),
   .inBackup(inBackup), .supplyGood(supplyGood));
`default_nettype wire

// *** tb/latched_sram_host_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_consts.svh"
module latched_sram_host_tb;
   logic mclk, rst, reqValid, reqBurst, backupReq, supplyGood, reqReady;
   logic rspValid, inBackup, ramEnableN, ramWriteN, ramDataOe, clash;
   logic [1:0]         reqOp;
   logic [`ADDR_W-1:0] reqAddr, ramAddr;
   logic [`DATA_W-1:0] reqWdata, rspRdata, ramDataOut, ramDataIn;
   logic [3:0]         refMem [512];
   logic [4:0]         expQ [$];
   logic [4:0]         e;
   logic [8:0]         adr [3] = '{9'h000, 9'h1ff, 9'h0a5};
   int err_count = 0;
   int n_tests = 0;
   int n;
   latched_sram_host uut (.mclk, .rst, .reqValid, .reqReady, .reqOp, .reqAddr,
      .reqWdata, .reqBurst, .rspValid, .rspRdata, .backupReq, .supplyGood,
      .inBackup, .ramEnableN, .ramWriteN, .ramAddr, .ramDataOut, .ramDataOe,
      .ramDataIn);
   ram_partner peer (.mclk, .enN(ramEnableN), .wrN(ramWriteN), .addr(ramAddr),
      .hostD(ramDataOut), .hostOe(ramDataOe), .bus(ramDataIn), .clash);
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask : chk_bit
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic req(input logic [1:0] op, input logic [8:0] a,
                      input logic [3:0] d, input logic b);
      int k;
      k = 0;
      @(posedge mclk);
      reqValid <= 1'b1;
      reqOp    <= op;
      reqAddr  <= a;
      reqWdata <= d;
      reqBurst <= b;
      @(posedge mclk);
      while (reqReady !== 1'b1 && k < 500) begin
         @(posedge mclk);
         k++;
      end
      if (k >= 500) begin
         err_count++;
         end_of_test;
      end
      reqValid <= 1'b0;
      expQ.push_back({op != 2'h1, refMem[a]});
      if (op != 2'h0) refMem[a] = d;
   endtask : req
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (clash !== 1'b0) chk_bit(clash, 1'b0);
      if (rspValid === 1'b1) begin
         if (expQ.size() == 0) chk_bit(1'b0, 1'b1);
         else begin
            e = expQ.pop_front();
            if (e[4]) chk(rspRdata, e[3:0]);
         end
      end
   end
   initial begin
      rst = 1'b1;
      {reqValid, reqBurst, backupReq, reqOp, reqAddr, reqWdata} = '0;
      supplyGood = 1'b1;
      void'($urandom(516));
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      foreach (adr[i]) req(2'h1, adr[i], 4'($urandom), 1'b0);
      foreach (adr[i]) req(2'h0, adr[i], 4'h0, 1'b0);
      $display("test boundary write read done");
      for (int i = 0; i < 3; i++) begin
         req(2'h1, 9'h010 + 9'(i), 4'($urandom), i < 2);
      end
      for (int i = 0; i < 3; i++) begin
         req(2'h0, 9'h010 + 9'(i), 4'h0, 1'b0);
      end
      $display("test burst done");
      req(2'h2, 9'h1ff, 4'($urandom), 1'b0);
      req(2'h2, 9'h1ff, 4'($urandom), 1'b0);
      req(2'h0, 9'h1ff, 4'h0, 1'b0);
      $display("test read modify write done");
      @(posedge mclk);
      backupReq <= 1'b1;
      n = 0;
      while (inBackup !== 1'b1 && n < 300) begin
         @(posedge mclk);
         n++;
      end
      chk_bit(inBackup, 1'b1);
      chk_bit(reqReady, 1'b0);
      if (n >= 300) end_of_test;
      supplyGood <= 1'b0;
      repeat (40) @(posedge mclk);
      supplyGood <= 1'b1;
      repeat (3) @(posedge mclk);
      backupReq <= 1'b0;
      foreach (adr[i]) req(2'h0, adr[i], 4'h0, 1'b0);
      $display("test backup done");
      n = 0;
      while (expQ.size() != 0 && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 2000) err_count++;
      end_of_test;
   end
endmodule : latched_sram_host_tb
`default_nettype wire

// *** tb/ram_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module ram_partner (
   input  wire logic       mclk,
   input  wire logic       enN,
   input  wire logic       wrN,
   input  wire logic [8:0] addr,
   input  wire logic [3:0] hostD,
   input  wire logic       hostOe,
   output logic      [3:0] bus,
   output logic            clash
);
   logic [3:0] mem_q [512];
   logic [8:0] lat_q;
   logic [3:0] pend_q;
   logic [3:0] last_q = 4'h0;
   int         cnt_q  = 0;
   logic       drv;
   always @(negedge enN) lat_q <= addr;
   always @(posedge mclk) begin
      cnt_q  <= enN ? 0 : cnt_q + 1;
      last_q <= bus;
      if (!enN && !wrN && hostOe) pend_q <= hostD;
   end
   always @(posedge (wrN | enN)) mem_q[lat_q] <= pend_q;
   assign drv = !enN && wrN && cnt_q >= 10;
   // Undriven bus toggles so a stale value can never look valid
   assign bus = hostOe ? hostD :
                (drv && cnt_q >= 30) ? mem_q[lat_q] : ~last_q;
   assign clash = hostOe && drv;
endmodule : ram_partner
`default_nettype wire
